// ---- pkg/pcs_pkg.sv ----
// constants for the power controller register bank
`default_nettype none
package pcs_pkg;
    localparam int          PCS_AW           = 6;
    localparam int          PCS_DW           = 24;
    // register indices
    localparam logic [5:0]  PCS_IDX_STAT_A   = 6'h00;
    localparam logic [5:0]  PCS_IDX_MASK_A   = 6'h01;
    localparam logic [5:0]  PCS_IDX_STAT_B   = 6'h03;
    localparam logic [5:0]  PCS_IDX_MASK_B   = 6'h04;
    localparam logic [5:0]  PCS_IDX_SENSE_B  = 6'h05;
    localparam logic [5:0]  PCS_IDX_PUMS     = 6'h06;
    localparam logic [5:0]  PCS_IDX_REV      = 6'h07;
    localparam logic [5:0]  PCS_IDX_FAULT    = 6'h08;
    localparam logic [5:0]  PCS_IDX_PWR_A    = 6'h0D;
    localparam logic [5:0]  PCS_IDX_PWR_B    = 6'h0E;
    localparam logic [5:0]  PCS_IDX_PWR_C    = 6'h0F;
    localparam logic [5:0]  PCS_IDX_MEM_A    = 6'h10;
    // implemented bit masks
    localparam logic [23:0] PCS_STAT_A_BITS  = 24'h002007;
    localparam logic [23:0] PCS_STAT_B_BITS  = 24'h1FFFFB;
    localparam logic [23:0] PCS_STAT_B_RST   = 24'h000080;
    // reset-domain membership inside the second status/mask pair
    localparam logic [23:0] PCS_B_RTC_BITS   = 24'h0006E3;
    localparam logic [23:0] PCS_B_OFF_BITS   = 24'h000118;
    localparam logic [23:0] PCS_B_SYS_BITS   = 24'h1FF800;
    localparam int          PCS_B_THERM_LSB  = 11;
    localparam int          PCS_B_SHORT_BIT  = 16;
    localparam int          PCS_B_PIN_LSB    = 17;
    localparam int          PCS_B_CLK_BIT    = 15;
    localparam logic [23:0] PCS_MASK_B_RST   = 24'h1FFFFF;
    localparam logic [23:0] PCS_SENSE_BITS   = 24'h00F818;
    localparam logic [23:0] PCS_FAULT_BITS   = 24'h001FFD;
    localparam int          PCS_SCP_EN_BIT   = 23;
    localparam int          PCS_PAGE_LSB     = 19;
    // power control a
    localparam logic [23:0] PCS_PWR_A_BITS   = 24'hF0027F;
    localparam logic [23:0] PCS_PWR_A_RST    = 24'h000040;
    localparam int          PCS_USEROFF_BIT  = 3;
    localparam int          PCS_KEEP_BIT     = 4;
    localparam int          PCS_UOCLK_BIT    = 5;
    localparam int          PCS_CLKEN_BIT    = 6;
    localparam int          PCS_NOTEXP_BIT   = 9;
    localparam int          PCS_COINV_LSB    = 20;
    localparam int          PCS_COINEN_BIT   = 23;
    // power control b
    localparam logic [23:0] PCS_PWR_B_BITS   = 24'h00FFFF;
    localparam int          PCS_CUTTMR_LSB   = 0;
    localparam int          PCS_CUTCNT_LSB   = 8;
    localparam int          PCS_CUTLIM_LSB   = 12;
    // power control c
    localparam logic [23:0] PCS_PWR_C_BITS   = 24'hE677F7;
    localparam logic [23:0] PCS_PWR_C_SYS    = 24'hE01000;
    localparam logic [23:0] PCS_PWR_C_RST    = 24'h422300;
    localparam int          PCS_STBYPOL_BIT  = 10;
    localparam int          PCS_WDEN_BIT     = 12;
endpackage : pcs_pkg
`default_nettype wire

// ---- rtl/pcs_regs.sv ----
// control and status register bank of the power controller, registers 0 to 16
`timescale 1ns/10ps
`default_nettype none
module pcs_regs (
    // clock and primary reset
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    // per-domain resets, active low, synchronous to clk_i
    input  wire logic                    rtc_poweron_reset_n_i,
    input  wire logic                    system_reset_n_i,
    input  wire logic                    off_reset_n_i,
    input  wire logic                    digital_reset_n_i,
    // register access port
    input  wire logic                    wr_en_i,
    input  wire logic                    rd_en_i,
    input  wire logic [pcs_pkg::PCS_AW-1:0] addr_i,
    input  wire logic [pcs_pkg::PCS_DW-1:0] wdata_i,
    output logic      [pcs_pkg::PCS_DW-1:0] rdata_o,
    // event pulses, one bit per status position
    input  wire logic [pcs_pkg::PCS_DW-1:0] event_a_i,
    input  wire logic [pcs_pkg::PCS_DW-1:0] event_b_i,
    input  wire logic [3:0]              therm_cross_i,
    input  wire logic                    short_detect_i,
    // live sense inputs
    input  wire logic [pcs_pkg::PCS_DW-1:0] sense_b_i,
    input  wire logic [5:0]              pums_i,
    input  wire logic [pcs_pkg::PCS_DW-1:0] fault_i,
    input  wire logic                    startup_i,
    input  wire logic                    cut_timer_expired_i,
    input  wire logic                    standby_i,
    input  wire logic                    user_off_state_i,
    // outputs to the rest of the device
    output logic                         irq_o,
    output logic                         short_disable_o,
    output logic                         standby_active_o,
    output logic                         processor_slow_clock_on_o,
    output logic                         rtc_supply_keep_o,
    output logic [pcs_pkg::PCS_DW-1:0]   power_control_a_o,
    output logic [pcs_pkg::PCS_DW-1:0]   power_control_b_o,
    output logic [pcs_pkg::PCS_DW-1:0]   power_control_c_o
);
    import pcs_pkg::*;

    // revision fields, arbitrary values
    parameter logic [2:0] METAL_REV = 3'h0;
    parameter logic [2:0] FULL_REV  = 3'h0;
    parameter logic [2:0] FIN_REV   = 3'h0;
    parameter logic [2:0] FAB_REV   = 3'h0;

    logic [PCS_DW-1:0] stat_a_r, mask_a_r, stat_b_r, mask_b_r;
    logic [PCS_DW-1:0] pwr_a_r, pwr_b_r, pwr_c_r, mem_a_r;
    logic [4:0]        page_r;
    logic              scp_en_r;
    logic              short_pulse_r;
    logic [PCS_DW-1:0] ev_b;

    function automatic logic hit(input logic [PCS_AW-1:0] idx);
        hit = wr_en_i && (addr_i == idx);
    endfunction : hit

    // ------------------------------------------------------------
    // interrupt pair a
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stat_a_r <= '0;
        end else if (!system_reset_n_i) begin
            stat_a_r <= '0;
        end else begin
            // set wins over a clear in the same cycle
            stat_a_r <= ((stat_a_r & ~(hit(PCS_IDX_STAT_A) ? wdata_i : '0)) | event_a_i)
                        & PCS_STAT_A_BITS;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_a_r <= PCS_STAT_A_BITS;
        end else if (!system_reset_n_i) begin
            mask_a_r <= PCS_STAT_A_BITS;
        end else if (hit(PCS_IDX_MASK_A)) begin
            mask_a_r <= wdata_i & PCS_STAT_A_BITS;
        end
    end

    // ------------------------------------------------------------
    // interrupt pair b
    // ------------------------------------------------------------
    always_comb begin
        ev_b = event_b_i;
        ev_b[PCS_B_THERM_LSB +: 4] = event_b_i[PCS_B_THERM_LSB +: 4] | therm_cross_i;
        ev_b[PCS_B_SHORT_BIT] = event_b_i[PCS_B_SHORT_BIT] | short_pulse_r;
        ev_b = ev_b & PCS_STAT_B_BITS;
    end

    // each bit drops to its own domain's default while that reset is held
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stat_b_r <= PCS_STAT_B_RST;
        end else begin
            stat_b_r <= ((stat_b_r & ~(hit(PCS_IDX_STAT_B) ? wdata_i : '0)) | ev_b)
                        & ~(rtc_poweron_reset_n_i ? '0 : PCS_B_RTC_BITS)
                        & ~(off_reset_n_i ? '0 : PCS_B_OFF_BITS)
                        & ~(system_reset_n_i ? '0 : PCS_B_SYS_BITS)
                        | (rtc_poweron_reset_n_i ? '0 : PCS_STAT_B_RST);
        end
    end

    // unused bit 2 is not a mask; it reads as one whatever is written
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_b_r <= PCS_MASK_B_RST;
        end else begin
            mask_b_r <= ((hit(PCS_IDX_MASK_B) ? wdata_i & PCS_STAT_B_BITS : mask_b_r)
                        | (rtc_poweron_reset_n_i ? '0 : PCS_B_RTC_BITS)
                        | (off_reset_n_i ? '0 : PCS_B_OFF_BITS)
                        | (system_reset_n_i ? '0 : PCS_B_SYS_BITS)) & PCS_STAT_B_BITS
                        | (PCS_MASK_B_RST & ~PCS_STAT_B_BITS);
        end
    end

    // ------------------------------------------------------------
    // page select and short-circuit protection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            page_r <= '0;
        end else if (!digital_reset_n_i) begin
            page_r <= '0;
        end else if (hit(PCS_IDX_REV)) begin
            page_r <= wdata_i[PCS_PAGE_LSB +: 5];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scp_en_r      <= 1'b0;
            short_pulse_r <= 1'b0;
        end else begin
            if (!system_reset_n_i) begin
                scp_en_r <= 1'b0;
            end else if (hit(PCS_IDX_FAULT)) begin
                scp_en_r <= wdata_i[PCS_SCP_EN_BIT];
            end
            short_pulse_r <= scp_en_r && short_detect_i;
        end
    end

    // regulator enable is dropped by the owner of that enable on this pulse
    assign short_disable_o = short_pulse_r;

    // ------------------------------------------------------------
    // power control registers and backup word
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_a_r <= PCS_PWR_A_RST;
        end else if (!rtc_poweron_reset_n_i) begin
            pwr_a_r <= PCS_PWR_A_RST;
        end else begin
            if (hit(PCS_IDX_PWR_A)) begin
                pwr_a_r <= wdata_i & PCS_PWR_A_BITS;
            end else if (startup_i && cut_timer_expired_i) begin
                pwr_a_r[PCS_NOTEXP_BIT] <= 1'b0;
            end
            if (!system_reset_n_i) begin
                pwr_a_r[PCS_USEROFF_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_b_r <= '0;
        end else if (!rtc_poweron_reset_n_i) begin
            pwr_b_r <= '0;
        end else if (hit(PCS_IDX_PWR_B)) begin
            pwr_b_r <= wdata_i & PCS_PWR_B_BITS;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_c_r <= PCS_PWR_C_RST;
        end else if (!rtc_poweron_reset_n_i) begin
            pwr_c_r <= PCS_PWR_C_RST;
        end else if (!system_reset_n_i) begin
            pwr_c_r <= (pwr_c_r & ~PCS_PWR_C_SYS) | (PCS_PWR_C_RST & PCS_PWR_C_SYS);
        end else if (hit(PCS_IDX_PWR_C)) begin
            pwr_c_r <= wdata_i & PCS_PWR_C_BITS;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_a_r <= '0;
        end else if (!rtc_poweron_reset_n_i) begin
            mem_a_r <= '0;
        end else if (hit(PCS_IDX_MEM_A)) begin
            mem_a_r <= wdata_i;
        end
    end

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    assign irq_o = |(stat_a_r & ~mask_a_r) || |(stat_b_r & ~mask_b_r);
    assign standby_active_o = standby_i ^ pwr_c_r[PCS_STBYPOL_BIT];
    assign rtc_supply_keep_o = pwr_a_r[PCS_KEEP_BIT];
    // keep-alive overrides everything; otherwise user-off needs its own keep bit
    assign processor_slow_clock_on_o = pwr_a_r[PCS_KEEP_BIT] ||
        (pwr_a_r[PCS_CLKEN_BIT] && (!user_off_state_i || pwr_a_r[PCS_UOCLK_BIT]));
    assign power_control_a_o = pwr_a_r;
    assign power_control_b_o = pwr_b_r;
    assign power_control_c_o = pwr_c_r;

    // ------------------------------------------------------------
    // read path, registered; unmapped indices read zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= '0;
        end else if (rd_en_i) begin
            if (addr_i == PCS_IDX_STAT_A) begin
                rdata_o <= stat_a_r;
            end else if (addr_i == PCS_IDX_MASK_A) begin
                rdata_o <= mask_a_r;
            end else if (addr_i == PCS_IDX_STAT_B) begin
                rdata_o <= stat_b_r;
            end else if (addr_i == PCS_IDX_MASK_B) begin
                rdata_o <= mask_b_r;
            end else if (addr_i == PCS_IDX_SENSE_B) begin
                rdata_o <= sense_b_i & PCS_SENSE_BITS;
            end else if (addr_i == PCS_IDX_PUMS) begin
                rdata_o <= {18'h00000, pums_i};
            end else if (addr_i == PCS_IDX_REV) begin
                rdata_o <= {page_r, 7'h00, FAB_REV, FIN_REV, FULL_REV, METAL_REV};
            end else if (addr_i == PCS_IDX_FAULT) begin
                rdata_o <= {scp_en_r, 23'h000000} | (fault_i & PCS_FAULT_BITS);
            end else if (addr_i == PCS_IDX_PWR_A) begin
                rdata_o <= pwr_a_r;
            end else if (addr_i == PCS_IDX_PWR_B) begin
                rdata_o <= pwr_b_r;
            end else if (addr_i == PCS_IDX_PWR_C) begin
                rdata_o <= pwr_c_r;
            end else if (addr_i == PCS_IDX_MEM_A) begin
                rdata_o <= mem_a_r;
            end else begin
                rdata_o <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_short_seen;
        scp_en_r && short_detect_i;
    endsequence

    AST_FLAG_HOLD_ZERO_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (system_reset_n_i && hit(PCS_IDX_STAT_A) && stat_a_r[0] && !wdata_i[0]) ##1 system_reset_n_i
        |-> stat_a_r[0]) else $error("flag lost on zero write");
    AST_FLAG_A_CLEAR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (hit(PCS_IDX_STAT_A) && wdata_i[13] && !event_a_i[13]) |=> !stat_a_r[13])
        else $error("low battery flag not cleared");
    AST_FLAG_A_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (system_reset_n_i && event_a_i[2]) |=> stat_a_r[2]) else $error("pen flag not set");
    AST_MASK_A_RESET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !system_reset_n_i |=> mask_a_r == PCS_STAT_A_BITS) else $error("mask a not reset");
    AST_THERM_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (system_reset_n_i && therm_cross_i[3]) |=> stat_b_r[14]) else $error("thermal flag missed");
    AST_SHORT_TRIP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (s_short_seen and system_reset_n_i) |=> short_disable_o ##1
        (stat_b_r[PCS_B_SHORT_BIT] || !$past(system_reset_n_i)))
        else $error("short trip not raised");
    AST_NO_SHORT_WHEN_OFF: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !scp_en_r |=> !short_disable_o) else $error("short trip while disabled");
    AST_MASK_B_OFF: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !off_reset_n_i |=> mask_b_r[3] && mask_b_r[4] && mask_b_r[8]) else $error("off domain mask");
    AST_IRQ: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ((stat_a_r[0] && !mask_a_r[0]) || (stat_b_r[11] && !mask_b_r[11])) |-> irq_o)
        else $error("irq missing");
    AST_STBY_POL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pwr_c_r[PCS_STBYPOL_BIT] |-> standby_active_o == !standby_i) else $error("standby polarity");
    AST_WD_SYSRST: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !system_reset_n_i |=> !pwr_c_r[PCS_WDEN_BIT] && pwr_c_r[22]) else $error("watchdog enable kept");
    AST_NOTEXP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rtc_poweron_reset_n_i && !hit(PCS_IDX_PWR_A) && startup_i && cut_timer_expired_i)
        |=> !pwr_a_r[PCS_NOTEXP_BIT]) else $error("expiry not recorded");

    // ------------------------------------------------------------
    // reset domains, field layout and derived outputs
    // ------------------------------------------------------------
    sequence s_rtc_hold;
        !rtc_poweron_reset_n_i;
    endsequence

    // system reset without the rtc reset, so rtc-domain fields must survive it
    sequence s_sys_hold;
        !system_reset_n_i && rtc_poweron_reset_n_i;
    endsequence

    sequence s_rev_read;
        rd_en_i && (addr_i == PCS_IDX_REV);
    endsequence

    AST_IRQ_QUIET: assert property (
        ((stat_a_r & ~mask_a_r) == '0 && (stat_b_r & ~mask_b_r) == '0) |-> !irq_o)
        else $error("irq with all flags masked");
    AST_MASK_A_WRITE: assert property (
        (system_reset_n_i && hit(PCS_IDX_MASK_A)) |=> mask_a_r == ($past(wdata_i) & PCS_STAT_A_BITS))
        else $error("mask a write lost");
    AST_WARM_SET: assert property ((rtc_poweron_reset_n_i && event_b_i[9]) |=> stat_b_r[9])
        else $error("warm flag not set");
    AST_CLK_FLAG: assert property (
        (system_reset_n_i && event_b_i[PCS_B_CLK_BIT]) |=> stat_b_r[PCS_B_CLK_BIT])
        else $error("clock change flag not set");
    AST_PIN_FLAG: assert property (
        (system_reset_n_i && event_b_i[PCS_B_PIN_LSB + 3]) |=> stat_b_r[PCS_B_PIN_LSB + 3])
        else $error("pin flag not set");
    AST_MASK_B_SYS: assert property (
        !system_reset_n_i |=> (mask_b_r & PCS_B_SYS_BITS) == PCS_B_SYS_BITS)
        else $error("system domain mask");
    AST_STAT_B_RTC: assert property (s_rtc_hold |=> stat_b_r[7] && !stat_b_r[0] && !stat_b_r[9])
        else $error("rtc domain flags");
    AST_STAT_B_OFF: assert property (!off_reset_n_i |=> !stat_b_r[3] && !stat_b_r[8])
        else $error("off domain flags");
    AST_REV_READ: assert property (
        s_rev_read |=> rdata_o[11:0] == {FAB_REV, FIN_REV, FULL_REV, METAL_REV} && rdata_o[18:12] == 7'h00)
        else $error("revision fields wrong");
    AST_FAULT_READ: assert property (
        (rd_en_i && addr_i == PCS_IDX_FAULT) |=> !rdata_o[1] && rdata_o[22:13] == 10'h000)
        else $error("fault reserved bits set");
    AST_USEROFF_SYS: assert property (s_sys_hold |=> !pwr_a_r[PCS_USEROFF_BIT])
        else $error("user-off command kept");
    AST_KEEP_ALL: assert property (rtc_supply_keep_o |-> processor_slow_clock_on_o)
        else $error("keep-alive lost slow clock");
    AST_CLK_USEROFF: assert property (
        (user_off_state_i && !pwr_a_r[PCS_KEEP_BIT] && !pwr_a_r[PCS_UOCLK_BIT]) |-> !processor_slow_clock_on_o)
        else $error("slow clock in user-off");
    AST_COIN_RTC: assert property (
        s_rtc_hold |=> pwr_a_r[PCS_COINV_LSB +: 3] == 3'h0 && !pwr_a_r[PCS_COINEN_BIT])
        else $error("coin charger not reset");
    AST_PWR_B_RTC: assert property (
        s_rtc_hold |=> pwr_b_r[PCS_CUTTMR_LSB +: 8] == 8'h00 && pwr_b_r[PCS_CUTCNT_LSB +: 4] == 4'h0
        && pwr_b_r[PCS_CUTLIM_LSB +: 4] == 4'h0) else $error("cut fields not reset");
    AST_PWR_C_RTC: assert property (s_rtc_hold |=> pwr_c_r == PCS_PWR_C_RST)
        else $error("power control c not reset");
    AST_PWR_C_KEEP: assert property (
        s_sys_hold |=> (pwr_c_r & ~PCS_PWR_C_SYS) == ($past(pwr_c_r) & ~PCS_PWR_C_SYS))
        else $error("rtc fields lost on system reset");
    AST_STBY_SYS: assert property (s_sys_hold |=> !pwr_c_r[21] && pwr_c_r[23:22] == 2'b01)
        else $error("standby controls not reset");
endmodule : pcs_regs
`default_nettype wire

// ---- testbench/pcs_host.sv ----
// host processor model driving the register access port
`timescale 1ns/10ps
`default_nettype none
module pcs_host (
    // clock and returned data
    input  wire logic                       clk_i,
    input  wire logic [pcs_pkg::PCS_DW-1:0] rdata_i,
    // access strobes
    output var logic                        wr_en_o,
    output var logic                        rd_en_o,
    output var logic  [pcs_pkg::PCS_AW-1:0] addr_o,
    output var logic  [pcs_pkg::PCS_DW-1:0] wdata_o
);
    import pcs_pkg::*;
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 6'h3F;
        wdata_o = 24'h000000;
    end
    task automatic wr(input logic [5:0] a, input logic [23:0] v);
        @(negedge clk_i);
        wr_en_o = 1'b1;
        addr_o  = a;
        wdata_o = v;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        wdata_o = ~v;  // released data is not left looking valid
    endtask : wr
    // data is registered at the read edge, so it is taken one edge later
    task automatic rd(input logic [5:0] a, output logic [23:0] v);
        @(negedge clk_i);
        rd_en_o = 1'b1;
        addr_o  = a;
        @(negedge clk_i);
        rd_en_o = 1'b0;
        v       = rdata_i;
    endtask : rd
    task automatic boot(input logic [23:0] v);
        wr(PCS_IDX_PWR_A, v | 24'h000200);
    endtask : boot
    task automatic protect_on;
        wr(PCS_IDX_FAULT, 24'h800000);
    endtask : protect_on
endmodule : pcs_host
`default_nettype wire

// ---- testbench/pcs_regs_test.sv ----
// self-checking bench for the power controller register bank
`timescale 1ns/10ps
`default_nettype none
module pcs_regs_test;
    import pcs_pkg::*;
    logic        clk, rst_n, rtc_n, sys_n, off_n, dig_n, wr_en, rd_en, shrt, sup, expd, stby, uoff;
    logic        irq, sdis, stact, sclk, keep;
    logic [5:0]  addr, pums;
    logic [3:0]  therm;
    logic [23:0] wdata, rdata, ev_a, ev_b, sense, fault, pa, pb, pc, d;
    int          fail_count, checks, n;
    logic [5:0]  ra [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 6'hC, 6'hD, 6'hE, 6'hF, 6'h10, 6'h3F};
    logic [23:0] re [16] = '{0, 24'h002007, 0, 24'h000080, 24'h1FFFFF, 0, 0, 0, 0, 0, 0,
                             24'h000040, 0, 24'h422300, 0, 0};
    logic [5:0]  wa [10] = '{1, 4, 7, 8, 9, 6'hD, 6'hE, 6'hF, 6'h10, 2};
    logic [23:0] we [10] = '{24'h002007, 24'h1FFFFF, 24'hF80000, 24'h800000, 0, 24'hF0027F,
                             24'h00FFFF, 24'hE677F7, 24'hFFFFFF, 0};
    pcs_host host (.clk_i(clk), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
                   .wdata_o(wdata));
    pcs_regs DUT (.clk_i(clk), .reset_n_i(rst_n), .rtc_poweron_reset_n_i(rtc_n), .system_reset_n_i(sys_n),
        .off_reset_n_i(off_n), .digital_reset_n_i(dig_n), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
        .wdata_i(wdata), .rdata_o(rdata), .event_a_i(ev_a), .event_b_i(ev_b), .therm_cross_i(therm),
        .short_detect_i(shrt), .sense_b_i(sense), .pums_i(pums), .fault_i(fault), .startup_i(sup),
        .cut_timer_expired_i(expd), .standby_i(stby), .user_off_state_i(uoff), .irq_o(irq),
        .short_disable_o(sdis), .standby_active_o(stact), .processor_slow_clock_on_o(sclk),
        .rtc_supply_keep_o(keep), .power_control_a_o(pa), .power_control_b_o(pb), .power_control_c_o(pc));
    always #2 clk = ~clk;
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rc(input logic [5:0] a, input logic [23:0] e);
        host.rd(a, d);
        chk($sformatf("reg %0d", a), e, d);
    endtask : rc
    // pulse inputs set by the caller are dropped at the next falling edge
    task automatic clr;
        @(negedge clk);
        {ev_a, ev_b, therm, shrt, sup, expd} = '0;
    endtask : clr
    task automatic drst(input logic [3:0] k);
        @(negedge clk);
        {rtc_n, sys_n, off_n, dig_n} = ~k;
        @(negedge clk);
        {rtc_n, sys_n, off_n, dig_n} = 4'hF;
    endtask : drst
    task automatic results;
        if (fail_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {rtc_n, sys_n, off_n, dig_n} = 4'hF;
        {ev_a, ev_b, therm, shrt, sup, expd, stby, uoff, sense, pums, fault} = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        // ----------------------------------------
        // defaults, access kinds, domain resets
        // ----------------------------------------
        for (int i = 0; i < 16; i++) rc(ra[i], re[i]);
        for (int i = 0; i < 10; i++) begin
            host.wr(wa[i], 24'hFFFFFF);
            rc(wa[i], we[i]);
        end
        chk("pwr a out", 24'hF0027F, pa);
        chk("pwr b out", 24'h00FFFF, pb);
        chk("pwr c out", 24'hE677F7, pc);
        chk("keep", 1, keep);
        host.wr(PCS_IDX_MASK_A, 0);
        host.wr(PCS_IDX_MASK_B, 0);
        drst(4'h4);
        rc(PCS_IDX_MASK_A, 24'h002007);
        rc(PCS_IDX_MASK_B, 24'h1FF804);
        rc(PCS_IDX_PWR_A, 24'hF00277);
        rc(PCS_IDX_PWR_C, 24'h4667F7);
        rc(PCS_IDX_FAULT, 0);
        drst(4'h2);
        rc(PCS_IDX_MASK_B, 24'h1FF91C);
        drst(4'h8);
        rc(PCS_IDX_MASK_B, 24'h1FFFFF);
        rc(PCS_IDX_PWR_A, 24'h000040);
        rc(PCS_IDX_PWR_C, 24'h422300);
        rc(PCS_IDX_REV, 24'hF80000);
        drst(4'h1);
        rc(PCS_IDX_REV, 0);
        // ----------------------------------------
        // flags, clearing and the interrupt line
        // ----------------------------------------
        @(negedge clk); ev_a = '1; clr;
        rc(PCS_IDX_STAT_A, 24'h002007);
        host.wr(PCS_IDX_STAT_A, 0);
        rc(PCS_IDX_STAT_A, 24'h002007);
        chk("irq masked", 0, irq);
        host.wr(PCS_IDX_MASK_A, 0);
        chk("irq open", 1, irq);
        host.wr(PCS_IDX_STAT_A, 24'h000001);
        rc(PCS_IDX_STAT_A, 24'h002006);
        host.wr(PCS_IDX_STAT_A, '1);
        chk("irq cleared", 0, irq);
        host.wr(PCS_IDX_STAT_B, '1);
        @(negedge clk); ev_b = '1; clr;
        rc(PCS_IDX_STAT_B, 24'h1FFFFB);
        host.wr(PCS_IDX_STAT_B, '1);
        @(negedge clk); therm = 4'hF; clr;
        rc(PCS_IDX_STAT_B, 24'h007800);
        host.wr(PCS_IDX_MASK_B, 24'h1FF7FF);
        chk("irq b", 1, irq);
        host.wr(PCS_IDX_STAT_B, 24'h000800);
        chk("irq b cleared", 0, irq);
        // ----------------------------------------
        // short protection, live sense, cut timer
        // ----------------------------------------
        for (int en = 1; en >= 0; en--) begin
            host.wr(PCS_IDX_STAT_B, '1);
            if (en == 1) host.protect_on;
            else host.wr(PCS_IDX_FAULT, 0);
            n = 0;
            @(negedge clk); shrt = 1'b1;
            for (int i = 0; i < 4; i++) begin
                @(negedge clk);
                shrt = 1'b0;
                n += int'(sdis);
            end
            chk("short cut", en, n);
            rc(PCS_IDX_STAT_B, en ? 24'h010000 : 24'h0);
        end
        sense = '1; fault = '1; pums = 6'h3F;
        rc(PCS_IDX_SENSE_B, 24'h00F818);
        rc(PCS_IDX_PUMS, 24'h00003F);
        rc(PCS_IDX_FAULT, 24'h001FFD);
        host.boot(24'h000040);
        @(negedge clk); sup = 1'b1; clr;
        rc(PCS_IDX_PWR_A, 24'h000240);
        @(negedge clk); sup = 1'b1; expd = 1'b1; clr;
        rc(PCS_IDX_PWR_A, 24'h000040);
        // ----------------------------------------
        // standby polarity and slow clock gating
        // ----------------------------------------
        stby = 1'b1;
        @(negedge clk); chk("standby high", 1, stact);
        host.wr(PCS_IDX_PWR_C, 24'h422700);
        @(negedge clk); chk("standby low", 0, stact);
        @(negedge clk); chk("slow clock", 1, sclk);
        @(negedge clk); uoff = 1'b1;
        @(negedge clk); chk("slow clock off", 0, sclk);
        host.wr(PCS_IDX_PWR_A, 24'h000060);
        @(negedge clk); chk("slow clock user off", 1, sclk);
        host.wr(PCS_IDX_PWR_A, 24'h000010);
        @(negedge clk); chk("slow clock kept", 1, sclk);
        chk("rtc supply kept", 1, keep);
        host.wr(PCS_IDX_PWR_A, 0);
        @(negedge clk); chk("slow clock none", 0, sclk);
        results();
    end
endmodule : pcs_regs_test
`default_nettype wire
